// ### rtl/pirqf_pkg.sv
package pirqf_pkg;

  // ==========================================================================
  // Register map, word aligned byte addresses
  localparam logic [7:0] ADDR_FLAGS_A   = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_B   = 8'h04;
  localparam logic [7:0] ADDR_FLAGS_C   = 8'h08;
  localparam logic [7:0] ADDR_ENABLES_A = 8'h0c;
  localparam logic [7:0] ADDR_ENABLES_B = 8'h10;
  localparam logic [7:0] ADDR_ENABLES_C = 8'h14;
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h18;
  localparam logic [7:0] ADDR_STATUS    = 8'h1c;
  localparam logic [7:0] ADDR_CLEAR     = 8'h20;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h24;

  // ==========================================================================
  // Implemented flag positions
  localparam logic [7:0] IMPL_MASK_A = 8'hff;
  localparam logic [7:0] IMPL_MASK_B = 8'hfd;
  localparam logic [7:0] IMPL_MASK_C = 8'h7a;
  // Software-writable positions; serial rx and tx are read-only
  localparam logic [7:0] WR_MASK_A   = 8'hcf;
  localparam logic [7:0] WR_MASK_B   = 8'hfd;
  localparam logic [7:0] WR_MASK_C   = 8'h7a;

  // ==========================================================================
  // Field positions
  localparam int BIT_TIMER1_GATE   = 7;
  localparam int BIT_ADC_DONE      = 6;
  localparam int BIT_SERIAL_RX     = 5;
  localparam int BIT_SERIAL_TX     = 4;
  localparam int BIT_SYNC_SERIAL   = 3;
  localparam int BIT_CAPCOMP1      = 2;
  localparam int BIT_TIMER2_MATCH  = 1;
  localparam int BIT_TIMER1_OVF    = 0;
  localparam int BIT_OSC_FAIL      = 7;
  localparam int BIT_COMPARATOR2   = 6;
  localparam int BIT_COMPARATOR1   = 5;
  localparam int BIT_EEPROM_DONE   = 4;
  localparam int BIT_BUS_COLLISION = 3;
  localparam int BIT_LCD_EVENT     = 2;
  localparam int BIT_CAPCOMP2      = 0;
  localparam int BIT_CAPCOMP5      = 6;
  localparam int BIT_CAPCOMP4      = 5;
  localparam int BIT_CAPCOMP3      = 4;
  localparam int BIT_TIMER6_MATCH  = 3;
  localparam int BIT_TIMER4_MATCH  = 1;
  localparam int BIT_GLOBAL_GATE   = 7;
  localparam int BIT_PERIPH_GATE   = 6;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_FLAGS   = 8'h00;
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_CTRL    = 8'h00;
  localparam logic [2:0] RST_STATUS  = 3'h0;

endpackage : pirqf_pkg

// ### rtl/pirqf_flag_reg.sv
`timescale 1ns/10ps

module pirqf_flag_reg #(
  parameter logic [7:0] IMPL_MASK = 8'hff,
  parameter logic [7:0] WR_MASK   = 8'hff
) (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic [7:0] set_evt,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] flags_ff
);

  logic [7:0] nxt_flags;

  // ==========================================================================
  // Per-bit flag update
  for (genvar i = 0; i < 8; i++)
  begin : g_bit
    always_comb
    begin
      nxt_flags[i] = flags_ff[i];
      if (wr_en && WR_MASK[i])
      begin
        nxt_flags[i] = wr_data[i];
      end
      if (set_evt[i])
      begin
        nxt_flags[i] = 1'b1;
      end
      if (!IMPL_MASK[i])
      begin
        nxt_flags[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      flags_ff <= pirqf_pkg::RST_FLAGS;
    end
    else
    begin
      flags_ff <= nxt_flags;
    end
  end

endmodule : pirqf_flag_reg

// ### rtl/pirqf_wb_slave.sv
`timescale 1ns/10ps

module pirqf_wb_slave (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire logic [0:0] wb_sel_i,
  output logic            wb_ack_o,
  output logic            acc_wr,
  output logic            acc_rd
);

  logic ack_ff;

  // ==========================================================================
  // One registered answer, ack high the cycle after the request; ack low the cycle after to frame each access
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
    end
  end

  assign wb_ack_o = ack_ff;
  assign acc_wr   = ack_ff && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];
  assign acc_rd   = wb_cyc_i && wb_stb_i && !wb_we_i;

endmodule : pirqf_wb_slave

// ### rtl/pirqf_bank.sv
`timescale 1ns/10ps

// What this block does
// - Flag reads 1 pending, 0 otherwise
// - Events set flags regardless of enables
// - All flags reset to zero
// - Serial rx/tx flags read-only, others writable
// - First register bit map, timers through serial
// - Second register map, bit 1 unimplemented
// - Third register map, bits 7,2,0 unimplemented
// - Forward periph_irq_req only with peripheral gate set; irq is not gated by it
module pirqf_bank (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  periph_evt_a,
  input  wire logic [7:0]  periph_evt_b,
  input  wire logic [7:0]  periph_evt_c,
  output logic             periph_irq_req,
  output logic             irq
);

  logic [7:0]  periph_req_flags_a;
  logic [7:0]  periph_req_flags_b;
  logic [7:0]  periph_req_flags_c;
  logic [7:0]  periph_irq_enables_a_ff;
  logic [7:0]  periph_irq_enables_b_ff;
  logic [7:0]  periph_irq_enables_c_ff;
  logic [7:0]  core_irq_control_ff;
  logic [2:0]  irq_status_ff;
  logic [2:0]  irq_enable_ff;
  logic [2:0]  nxt_irq_status;
  logic [2:0]  rise_evt;
  logic [2:0]  pend_any;
  logic [2:0]  pend_any_ff;
  logic [31:0] nxt_dat;
  logic [31:0] dat_ff;
  logic        acc_wr;
  logic        acc_rd;
  logic        wr_flags_a;
  logic        wr_flags_b;
  logic        wr_flags_c;
  logic        wr_enables_a;
  logic        wr_enables_b;
  logic        wr_enables_c;
  logic        wr_core_ctrl;
  logic        wr_clear;
  logic        wr_irq_en;
  logic        timer1_gate_flag;
  logic        adc_done_flag;
  logic        serial_rx_flag;
  logic        serial_tx_flag;
  logic        sync_serial_flag;
  logic        capcomp1_flag;
  logic        timer2_match_flag;
  logic        timer1_overflow_flag;
  logic        osc_fail_flag;
  logic        comparator2_flag;
  logic        comparator1_flag;
  logic        eeprom_write_done_flag;
  logic        bus_collision_flag;
  logic        lcd_event_flag;
  logic        capcomp2_flag;
  logic        capcomp5_flag;
  logic        capcomp4_flag;
  logic        capcomp3_flag;
  logic        timer6_match_flag;
  logic        timer4_match_flag;

  // ==========================================================================
  // Bus slave
  pirqf_wb_slave u_wb (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_sel_i (wb_sel_i[0:0]),
    .wb_ack_o (wb_ack_o),
    .acc_wr   (acc_wr),
    .acc_rd   (acc_rd)
  );

  assign wr_flags_a = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_FLAGS_A);
  assign wr_flags_b = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_FLAGS_B);
  assign wr_flags_c = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_FLAGS_C);

  // ==========================================================================
  // Request flag registers
  pirqf_flag_reg #(
    .IMPL_MASK (pirqf_pkg::IMPL_MASK_A),
    .WR_MASK   (pirqf_pkg::WR_MASK_A)
  ) u_flags_a (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .set_evt  (periph_evt_a),
    .wr_en    (wr_flags_a),
    .wr_data  (wb_dat_i[7:0]),
    .flags_ff (periph_req_flags_a)
  );

  pirqf_flag_reg #(
    .IMPL_MASK (pirqf_pkg::IMPL_MASK_B),
    .WR_MASK   (pirqf_pkg::WR_MASK_B)
  ) u_flags_b (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .set_evt  (periph_evt_b),
    .wr_en    (wr_flags_b),
    .wr_data  (wb_dat_i[7:0]),
    .flags_ff (periph_req_flags_b)
  );

  pirqf_flag_reg #(
    .IMPL_MASK (pirqf_pkg::IMPL_MASK_C),
    .WR_MASK   (pirqf_pkg::WR_MASK_C)
  ) u_flags_c (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .set_evt  (periph_evt_c),
    .wr_en    (wr_flags_c),
    .wr_data  (wb_dat_i[7:0]),
    .flags_ff (periph_req_flags_c)
  );

  // ==========================================================================
  // Named flags, one per peripheral source
  assign timer1_gate_flag       = periph_req_flags_a[pirqf_pkg::BIT_TIMER1_GATE];
  assign adc_done_flag          = periph_req_flags_a[pirqf_pkg::BIT_ADC_DONE];
  assign serial_rx_flag         = periph_req_flags_a[pirqf_pkg::BIT_SERIAL_RX];
  assign serial_tx_flag         = periph_req_flags_a[pirqf_pkg::BIT_SERIAL_TX];
  assign sync_serial_flag       = periph_req_flags_a[pirqf_pkg::BIT_SYNC_SERIAL];
  assign capcomp1_flag          = periph_req_flags_a[pirqf_pkg::BIT_CAPCOMP1];
  assign timer2_match_flag      = periph_req_flags_a[pirqf_pkg::BIT_TIMER2_MATCH];
  assign timer1_overflow_flag   = periph_req_flags_a[pirqf_pkg::BIT_TIMER1_OVF];
  assign osc_fail_flag          = periph_req_flags_b[pirqf_pkg::BIT_OSC_FAIL];
  assign comparator2_flag       = periph_req_flags_b[pirqf_pkg::BIT_COMPARATOR2];
  assign comparator1_flag       = periph_req_flags_b[pirqf_pkg::BIT_COMPARATOR1];
  assign eeprom_write_done_flag = periph_req_flags_b[pirqf_pkg::BIT_EEPROM_DONE];
  assign bus_collision_flag     = periph_req_flags_b[pirqf_pkg::BIT_BUS_COLLISION];
  assign lcd_event_flag         = periph_req_flags_b[pirqf_pkg::BIT_LCD_EVENT];
  assign capcomp2_flag          = periph_req_flags_b[pirqf_pkg::BIT_CAPCOMP2];
  assign capcomp5_flag          = periph_req_flags_c[pirqf_pkg::BIT_CAPCOMP5];
  assign capcomp4_flag          = periph_req_flags_c[pirqf_pkg::BIT_CAPCOMP4];
  assign capcomp3_flag          = periph_req_flags_c[pirqf_pkg::BIT_CAPCOMP3];
  assign timer6_match_flag      = periph_req_flags_c[pirqf_pkg::BIT_TIMER6_MATCH];
  assign timer4_match_flag      = periph_req_flags_c[pirqf_pkg::BIT_TIMER4_MATCH];

  // ==========================================================================
  // Write strobes, only on the ack cycle so each write lands once
  assign wr_enables_a = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_ENABLES_A);
  assign wr_enables_b = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_ENABLES_B);
  assign wr_enables_c = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_ENABLES_C);
  assign wr_core_ctrl = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_CORE_CTRL);
  assign wr_clear     = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_CLEAR);
  assign wr_irq_en    = acc_wr && (wb_adr_i == pirqf_pkg::ADDR_IRQ_EN);

  // ==========================================================================
  // Enable registers, unimplemented bits held at zero
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      periph_irq_enables_a_ff <= pirqf_pkg::RST_ENABLES;
    end
    else if (wr_enables_a)
    begin
      periph_irq_enables_a_ff <= wb_dat_i[7:0] & pirqf_pkg::IMPL_MASK_A;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      periph_irq_enables_b_ff <= pirqf_pkg::RST_ENABLES;
    end
    else if (wr_enables_b)
    begin
      periph_irq_enables_b_ff <= wb_dat_i[7:0] & pirqf_pkg::IMPL_MASK_B;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      periph_irq_enables_c_ff <= pirqf_pkg::RST_ENABLES;
    end
    else if (wr_enables_c)
    begin
      periph_irq_enables_c_ff <= wb_dat_i[7:0] & pirqf_pkg::IMPL_MASK_C;
    end
  end

  // ==========================================================================
  // Core control; global gate stored only, the core applies it
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      core_irq_control_ff <= pirqf_pkg::RST_CTRL;
    end
    else if (wr_core_ctrl)
    begin
      core_irq_control_ff <= wb_dat_i[7:0];
    end
  end

  // ==========================================================================
  // Request to the core; the global gate is the core's to apply
  assign pend_any[0] = |(periph_req_flags_a & periph_irq_enables_a_ff);
  assign pend_any[1] = |(periph_req_flags_b & periph_irq_enables_b_ff);
  assign pend_any[2] = |(periph_req_flags_c & periph_irq_enables_c_ff);

  assign periph_irq_req = core_irq_control_ff[pirqf_pkg::BIT_PERIPH_GATE]
                          && (|pend_any);

  // ==========================================================================
  // Sticky status: one bit per register, set when its enabled requests rise from none to any
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pend_any_ff <= 3'h0;
    end
    else
    begin
      pend_any_ff <= pend_any;
    end
  end

  assign rise_evt = pend_any & ~pend_any_ff;

  always_comb
  begin
    nxt_irq_status = irq_status_ff;
    if (wr_clear)
    begin
      nxt_irq_status = nxt_irq_status & ~wb_dat_i[2:0];
    end
    nxt_irq_status = nxt_irq_status | rise_evt;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      irq_status_ff <= pirqf_pkg::RST_STATUS;
    end
    else
    begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      irq_enable_ff <= pirqf_pkg::RST_STATUS;
    end
    else if (wr_irq_en)
    begin
      irq_enable_ff <= wb_dat_i[2:0];
    end
  end

  assign irq = |(irq_status_ff & irq_enable_ff);

  // ==========================================================================
  // Read data, registered so it lands with ack
  always_comb
  begin
    nxt_dat = 32'h0000_0000;
    unique case (wb_adr_i)
      pirqf_pkg::ADDR_FLAGS_A:
      begin
        nxt_dat[7:0] = {timer1_gate_flag, adc_done_flag, serial_rx_flag, serial_tx_flag,
                        sync_serial_flag, capcomp1_flag, timer2_match_flag,
                        timer1_overflow_flag};
      end
      pirqf_pkg::ADDR_FLAGS_B:
      begin
        nxt_dat[7:0] = {osc_fail_flag, comparator2_flag, comparator1_flag, eeprom_write_done_flag,
                        bus_collision_flag, lcd_event_flag, 1'b0, capcomp2_flag};
      end
      pirqf_pkg::ADDR_FLAGS_C:
      begin
        nxt_dat[7:0] = {1'b0, capcomp5_flag, capcomp4_flag, capcomp3_flag, timer6_match_flag,
                        1'b0, timer4_match_flag, 1'b0};
      end
      pirqf_pkg::ADDR_ENABLES_A:
      begin
        nxt_dat[7:0] = periph_irq_enables_a_ff;
      end
      pirqf_pkg::ADDR_ENABLES_B:
      begin
        nxt_dat[7:0] = periph_irq_enables_b_ff;
      end
      pirqf_pkg::ADDR_ENABLES_C:
      begin
        nxt_dat[7:0] = periph_irq_enables_c_ff;
      end
      pirqf_pkg::ADDR_CORE_CTRL:
      begin
        nxt_dat[7:0] = core_irq_control_ff;
      end
      pirqf_pkg::ADDR_STATUS:
      begin
        nxt_dat[2:0] = irq_status_ff;
      end
      pirqf_pkg::ADDR_IRQ_EN:
      begin
        nxt_dat[2:0] = irq_enable_ff;
      end
      default:
      begin
        nxt_dat = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      dat_ff <= 32'h0000_0000;
    end
    else if (acc_rd)
    begin
      dat_ff <= nxt_dat;
    end
  end

  assign wb_dat_o = dat_ff;

endmodule : pirqf_bank

// ### bench/pirqf_bank_sva.sv
`timescale 1ns/10ps
// ========
// Bus and interrupt checks
module pirqf_bank_sva (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        periph_irq_req,
  input wire logic        irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic rd_req;
  logic wr_req;
  assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
  AST_ACK_NEXT: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-cycle answer");
  AST_RST_QUIET: assert property ($fell(sys_rst) |-> !irq && !periph_irq_req && wb_dat_o == 32'h0)
    else $error("outputs not cleared by reset");
  AST_REQ_HOLD: assert property (periph_irq_req && !wr_req |=> periph_irq_req)
    else $error("request dropped without a write");
  AST_IRQ_HOLD: assert property (irq && !wr_req |=> irq)
    else $error("irq dropped without a write");
  AST_UPPER_ZERO: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_B_GAP: assert property (rd_req && wb_adr_i == 8'h04 |=> wb_dat_o[1] == 1'b0)
    else $error("flags b bit 1 not zero");
  AST_C_GAP: assert property (rd_req && wb_adr_i == 8'h08 |=> (wb_dat_o[7:0] & 8'h85) == 8'h0)
    else $error("flags c gap bits not zero");
  AST_UNMAPPED: assert property (rd_req && wb_adr_i > 8'h24 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  COV_IRQ: cover property ($rose(irq));
  COV_REQ: cover property ($rose(periph_irq_req));
  COV_WR: cover property (wr_req && wb_ack_o);
endmodule : pirqf_bank_sva

bind pirqf_bank pirqf_bank_sva u_sva (.core_clk(core_clk), .sys_rst(sys_rst),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .periph_irq_req(periph_irq_req), .irq(irq));

// ### bench/pirqf_periph_model.sv
`timescale 1ns/10ps
// ========
// Peripheral event source
module pirqf_periph_model (
  input  wire logic       core_clk,
  input  wire logic       sys_rst,
  input  wire logic       fire,
  input  wire logic [1:0] which,
  input  wire logic [7:0] pattern,
  output logic      [7:0] evt_a,
  output logic      [7:0] evt_b,
  output logic      [7:0] evt_c
);
  // One-cycle strobes; flags are sticky so a pulse is enough
  always_ff @(posedge core_clk)
  begin
    evt_a <= (!sys_rst && fire && which == 2'd0) ? pattern : 8'h00;
    evt_b <= (!sys_rst && fire && which == 2'd1) ? pattern : 8'h00;
    evt_c <= (!sys_rst && fire && which == 2'd2) ? pattern : 8'h00;
  end
endmodule : pirqf_periph_model

// ### bench/pirqf_bank_tb.sv
`timescale 1ns/10ps
// ========
// Bench top
module pirqf_bank_tb;
  logic        core_clk = 1'b0, sys_rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        fire = 1'b0, race = 1'b0, ack, preq, irq;
  logic [1:0]  which = 2'd0;
  logic [3:0]  sel = 4'h0, wsel = 4'hf;
  logic [7:0]  adr = 8'h0, pat = 8'h0, ea, eb, ec;
  logic [31:0] wdat = 32'h0, rdat, q, lfsr = 32'hbb86;
  int          err_count = 0, checks_done = 0, cycles = 0;
  int          mdl [3] = '{0, 0, 0};
  int          impl [3] = '{8'hff, 8'hfd, 8'h7a};
  int          wrm [3] = '{8'hcf, 8'hfd, 8'h7a};
  always #4 core_clk = ~core_clk;
  pirqf_periph_model u_periph (.core_clk(core_clk), .sys_rst(sys_rst), .fire(fire),
    .which(which), .pattern(pat), .evt_a(ea), .evt_b(eb), .evt_c(ec));
  pirqf_bank dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .periph_evt_a(ea), .periph_evt_b(eb), .periph_evt_c(ec),
    .periph_irq_req(preq), .irq(irq));
  function automatic logic [31:0] nxt_lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04c11db7 : 32'h0);
  endfunction : nxt_lfsr
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Race raises an event in step with the write, to land on its ack edge
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= wsel;
    fire <= race;
    @(posedge core_clk);
    fire <= 1'b0;
    while (ack !== 1'b1) @(posedge core_clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
  endtask : xfer
  task automatic fire_evt(input logic [1:0] r, input logic [7:0] p);
    @(posedge core_clk);
    fire <= 1'b1;
    which <= r;
    pat <= p;
    @(posedge core_clk);
    fire <= 1'b0;
    mdl[r] = mdl[r] | (p & impl[r]);
    repeat (3) @(posedge core_clk);
  endtask : fire_evt
  task automatic final_report;
    if (err_count == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      final_report();
    end
  end
  initial
  begin
    int k;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (k = 0; k < 3; k++)
    begin
      xfer(8'(4 * k), 1'b0, 8'h0);
      chk(q, 32'h0);
      fire_evt(2'(k), 8'hff);
      xfer(8'(4 * k), 1'b0, 8'h0);
      chk(q, 32'(mdl[k]));
      xfer(8'(4 * k), 1'b1, 8'h0);
      mdl[k] = mdl[k] & impl[k] & ~wrm[k];
      xfer(8'(4 * k), 1'b0, 8'h0);
      chk(q, 32'(mdl[k]));
    end
    for (int i = 0; i < 12; i++)
    begin
      lfsr = nxt_lfsr(lfsr);
      k = int'(lfsr[17:16]) % 3;
      xfer(8'(4 * k), 1'b1, lfsr[7:0]);
      mdl[k] = ((mdl[k] & ~wrm[k]) | (lfsr[7:0] & wrm[k])) & impl[k];
      fire_evt(2'(k), lfsr[15:8]);
      xfer(8'(4 * k), 1'b0, 8'h0);
      chk(q, 32'(mdl[k]));
    end
    which <= 2'd0;
    pat <= 8'h05;
    race = 1'b1;
    xfer(8'h00, 1'b1, 8'h00);
    race = 1'b0;
    xfer(8'h00, 1'b0, 8'h0);
    chk(q, 32'h35);
    xfer(8'h00, 1'b1, 8'h00);
    xfer(8'h0c, 1'b1, 8'h01);
    xfer(8'h24, 1'b1, 8'h01);
    xfer(8'h18, 1'b1, 8'hc0);
    xfer(8'h18, 1'b0, 8'h0);
    chk(q, 32'hc0);
    chk({31'h0, preq}, 32'h0);
    fire_evt(2'd0, 8'h01);
    chk({30'h0, preq, irq}, 32'h3);
    xfer(8'h1c, 1'b0, 8'h0);
    chk(q, 32'h1);
    xfer(8'h24, 1'b1, 8'h00);
    @(posedge core_clk);
    chk({30'h0, preq, irq}, 32'h2);
    xfer(8'h20, 1'b1, 8'h01);
    xfer(8'h24, 1'b1, 8'h01);
    @(posedge core_clk);
    chk({30'h0, preq, irq}, 32'h2);
    xfer(8'h18, 1'b1, 8'h80);
    @(posedge core_clk);
    chk({30'h0, preq, irq}, 32'h0);
    xfer(8'h40, 1'b0, 8'h0);
    chk(q, 32'h0);
    wsel = 4'he;
    xfer(8'h00, 1'b1, 8'h00);
    wsel = 4'hf;
    xfer(8'h00, 1'b0, 8'h0);
    chk(q, 32'h31);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    xfer(8'h00, 1'b0, 8'h0);
    chk(q, 32'h0);
    final_report();
  end
endmodule : pirqf_bank_tb
